// ===== fspc_cfg.svh
// Constants of the flash self-programming controller: offsets, field
// positions, command patterns, window lengths and operation timing.
// Assumes inclusion by bare name from the package and the design module.
`ifndef FSPC_CFG_SVH
`define FSPC_CFG_SVH
`define FSPC_AW              12
`define FSPC_CTRL_IDX        12'h037
`define FSPC_CTRL_ADDR       (`FSPC_CTRL_IDX * 12'h004)
`define FSPC_CTRL_RST        8'h00
`define FSPC_BIT_BUFFER_CLEAR_BIT        4
`define FSPC_BIT_FUSE_LOCK_READ_BIT        3
`define FSPC_BIT_PAGE_WRITE_BIT       2
`define FSPC_BIT_PAGE_ERASE_BIT       1
`define FSPC_BIT_STORE_ENABLE_BIT       0
`define FSPC_CMD_CLR         5'h11
`define FSPC_CMD_RFL         5'h09
`define FSPC_CMD_WR          5'h05
`define FSPC_CMD_ERS         5'h03
`define FSPC_CMD_LOAD        5'h01
`define FSPC_SPM_WIN         3'h4
`define FSPC_LPM_WIN         3'h3
`define FSPC_Z_FUSE_LO       16'h0000
`define FSPC_Z_LOCK          16'h0001
`define FSPC_Z_FUSE_HI       16'h0003
`define FSPC_UNUSED_RD       8'hFF
`define FSPC_OP_MIN_NS       3700000
`define FSPC_OP_MAX_NS       4500000
`define FSPC_CLK_NS          50
`endif

// ===== fspc_core_model.sv
// Processor core model issuing store and load program memory pulses.
// Assumes the testbench calls its tasks; it issues no store while halted, but loads regardless.
`timescale 1ns/10ps
module fspc_core_model (
  input  wire logic        clk,         // System clock
  input  wire logic        core_halt,   // Halt request
  input  wire logic        lpm_special, // Fuse byte valid
  input  wire logic        lpm_normal,  // Plain read
  input  wire logic [7:0]  lpm_data,    // Fuse or lock byte
  output logic             core_spm,    // Store pulse
  output logic             core_lpm,    // Load pulse
  output logic [15:0]      core_z,      // Pointer pair
  output logic [15:0]      core_data    // Low register pair
);
  ////////////////////////////////////////////////////////////
  // Idle at time zero
  initial begin
    core_spm = 1'h0;
    core_lpm = 1'h0;
    core_z = 16'h0;
    core_data = 16'h0;
  end
  // Store pulse; pointer and data scrambled after so stale values never help
  task automatic store_program_memory_instr(input logic [15:0] z, input logic [15:0] d);
    @(posedge clk);
    if (core_halt !== 1'h1) begin
      core_spm <= 1'h1;
      core_z <= z;
      core_data <= d;
      @(posedge clk);
      core_spm <= 1'h0;
      core_z <= ~z;
      core_data <= ~d;
    end
  endtask
  // Load pulse with pointer set; answer taken one cycle later
  task automatic load_program_memory_instr(input logic [15:0] z, output logic sp, nm, output logic [7:0] d);
    @(posedge clk);
    core_lpm <= 1'h1;
    core_z <= z;
    @(posedge clk);
    core_lpm <= 1'h0;
    core_z <= ~z;
    @(posedge clk);
    sp = lpm_special;
    nm = lpm_normal;
    d = lpm_data;
  endtask
endmodule

// ===== fspc_monitor.sv
// Port checker for the flash self-programming controller.
// Assumes binding to fspc_top; OP_CYCLES follows the bound instance.
`timescale 1ns/10ps
module fspc_monitor #(
  parameter int OP_CYCLES = 20 // Timed op length in cycles
) (
  input wire logic        clk,                    // System clock
  input wire logic        resetn,                 // System reset
  input wire logic        por_n,                  // Op timer reset
  input wire logic [31:0] prdata,                 // APB read data
  input wire logic        pready,                 // APB ready
  input wire logic        core_lpm,               // Load pulse
  input wire logic [15:0] core_z,                 // Pointer
  input wire logic [7:0]  lpm_data,               // Fuse or lock byte
  input wire logic        lpm_special,            // Special read done
  input wire logic        lpm_normal,             // Plain read
  input wire logic        lpm_byte_hi,            // Byte select
  input wire logic        core_halt,              // Halt request
  input wire logic        flash_erase_go,         // Erase start
  input wire logic        eeprom_write_busy_flag, // EEPROM writing
  input wire logic [7:0]  low_fuse_prog,          // Programmed fuses
  input wire logic [1:0]  lock_prog               // Programmed locks
);
  logic [31:0] hcnt;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////
  // Halt length counter; on por_n so a system reset cannot hide a short op
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) hcnt <= 32'h0;
    else hcnt <= core_halt ? hcnt + 32'h1 : 32'h0;
  end
  chk_reserved_zero: assert property (pready |-> prdata[31:5] == 27'h0) else $error("reserved bits set");
  chk_lock_value: assert property (core_lpm && core_z == 16'h0001 ##1 lpm_special
    |-> lpm_data == {6'h3F, ~$past(lock_prog)}) else $error("lock byte wrong");
  chk_low_fuse: assert property (core_lpm && core_z == 16'h0000 ##1 lpm_special
    |-> lpm_data == ~$past(low_fuse_prog)) else $error("low fuse wrong");
  chk_eeprom_block: assert property (core_lpm && eeprom_write_busy_flag |=> !lpm_special) else $error("read not blocked");
  chk_byte_select: assert property (core_lpm |=> lpm_byte_hi == $past(core_z[0])) else $error("byte select wrong");
  chk_lpm_answer: assert property (core_lpm |=> lpm_special ^ lpm_normal) else $error("load answer wrong");
  chk_erase_halt: assert property (flash_erase_go |-> core_halt ##1 core_halt[*3]) else $error("erase no halt");
  chk_halt_length: assert property (disable iff (!por_n) $fell(core_halt) |-> hcnt == OP_CYCLES)
    else $error("op length wrong");
endmodule
bind fspc_top fspc_monitor #(.OP_CYCLES(OP_CYCLES)) fspc_monitor_i (.*);

// ===== fspc_pkg.sv
// Types shared by the flash self-programming controller.
// Assumes fspc_cfg.svh sits in the same folder.
`include "fspc_cfg.svh"
package fspc_pkg;
  // Timed flash operation kinds
  typedef enum logic [1:0] {FSPC_OP_IDLE, FSPC_OP_ERASE, FSPC_OP_WRITE} fspc_op_t;
endpackage

// ===== fspc_top.sv
// Flash self-programming controller: control register on APB, store and
// load program memory instruction handling, page buffer and op timer.
// Assumes the core pulses core_spm/core_lpm for one clk with pointer and data
// valid, and that the flash macro reads the page buffer through buf_rd_*.
//
// Added by the designer: the APB register port.
`timescale 1ns/10ps
`include "fspc_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
module fspc_top
  import fspc_pkg::*;
#(
  parameter int PAGE_WORDS = 32,                             // Words per flash page
  parameter int OP_CYCLES  = (`FSPC_OP_MIN_NS + `FSPC_CLK_NS - 1) / `FSPC_CLK_NS // Op length
) (
  input  wire logic                          clk,            // System clock, 20 MHz
  input  wire logic                          resetn,         // System reset, async, low
  input  wire logic                          por_n,          // Power-on reset for op timer
  input  wire logic [`FSPC_AW-1:0]           paddr,          // APB address
  input  wire logic                          psel,           // APB select
  input  wire logic                          penable,        // APB enable
  input  wire logic                          pwrite,         // APB direction
  input  wire logic [31:0]                   pwdata,         // APB write data
  output logic [31:0]                        prdata,         // APB read data
  output logic                               pready,         // APB ready
  output logic                               pslverr,        // APB error, unmapped
  input  wire logic                          core_spm,       // Store instruction pulse
  input  wire logic                          core_lpm,       // Load instruction pulse
  input  wire logic [15:0]                   core_z,         // Pointer register pair
  input  wire logic [15:0]                   core_data,      // Low register pair data
  output logic [7:0]                         lpm_data,       // Fuse or lock byte
  output logic                               lpm_special,    // Pulse: lpm_data valid
  output logic                               lpm_normal,     // Pulse: read flash as usual
  output logic                               lpm_byte_hi,    // Byte select of that read
  output logic                               core_halt,      // Halt request to core
  input  wire logic                          eeprom_write_busy_flag, // EEPROM writing
  input  wire logic [7:0]                    low_fuse_prog,  // 1 = fuse programmed
  input  wire logic [7:0]                    high_fuse_prog, // 1 = fuse programmed
  input  wire logic [1:0]                    lock_prog,      // 1 = lock bit programmed
  output logic [15-$clog2(PAGE_WORDS):0]     flash_page,     // Page of running op
  output logic                               flash_erase_go, // Pulse: start page erase
  output logic                               flash_write_go, // Pulse: start page write
  output logic                               flash_busy,     // Timed op running
  input  wire logic [$clog2(PAGE_WORDS)-1:0] buf_rd_idx,     // Buffer read index
  output logic [15:0]                        buf_rd_data     // Buffer read word
);
  import fspc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Overview of operation
  // The control register holds five command bits: buffer clear, fuse/lock
  // read, page write, page erase and store enable. A write over APB only
  // lands when its low five bits form one of the accepted patterns, the
  // EEPROM is idle and no timed operation runs. Anything else is dropped
  // without an error response, so software reads back the old value.
  //
  // Every accepted write restarts a small arm window counter. The store
  // instruction is honoured while the counter is below four, and the
  // fuse/lock read only while it is below three. When the window runs out,
  // all command bits drop together. That way a half-armed command cannot
  // survive into code that never meant to use it.
  //
  // The page buffer is a loaded flag per word plus the word itself.
  // Clearing the buffer only drops the flags. The flash macro sees zero for
  // an empty slot, so stale words never leak into a page write. Trade-off:
  // the words stay in the array, which costs no gates, but anyone peeking
  // at the raw array may see old data.
  //
  // The timed operation sits on its own power-on reset. A system reset in
  // the middle of a page erase or write clears the control side but lets
  // the flash finish, since a half-programmed page is worse than a late
  // restart of the core. The core stays halted until the timer ends.

  localparam int WB = $clog2(PAGE_WORDS);
  localparam int PB = 15 - WB;
  localparam int TW = $clog2(OP_CYCLES + 1);
  localparam logic [TW-1:0] OP_LAST = TW'(OP_CYCLES - 1);

  // Control and buffer state, cleared by system reset.
  // The buffer words and their loaded flags live here as well, so a system
  // reset empties the buffer along with the register.
  typedef struct packed {
    logic [4:0]                  cmd;
    logic [2:0]                  win;
    logic [PAGE_WORDS-1:0][15:0] buf_w;
    logic [PAGE_WORDS-1:0]       used;
    logic                        ee_q;
    logic [7:0]                  lpm_data;
    logic                        lpm_special;
    logic                        lpm_normal;
    logic                        lpm_byte_hi;
    logic [31:0]                 prdata;
    logic                        pready;
    logic                        pslverr;
    logic [15:0]                 buf_rd;
  } fspc_ctl_t;

  // Timed operation state, only cleared at power-on
  typedef struct packed {
    fspc_op_t      st;
    logic [TW-1:0] timer;
    logic [PB:0]   page;
    logic          erase_go;
    logic          write_go;
    logic          halt;
    logic          busy;
    logic          done_wr;
    logic          done;
  } fspc_op_st_t;

  fspc_ctl_t   c_reg, c_next;
  fspc_op_st_t o_reg, o_next;

  // Buffer slot addressed by a store pointer; bit zero picks a byte, not a word
  function automatic logic [WB-1:0] slot_of(input logic [15:0] z);
    return z[WB:1];
  endfunction

  // Byte of the lock/fuse space picked by the pointer. Inputs are 1 when
  // a bit is programmed, so every bit is inverted on the way out. Pointer
  // values outside the three defined ones read as all ones, and the lock
  // byte's unused upper bits read as one as well.
  function automatic logic [7:0] fuse_read(input logic [15:0] z);
    logic [7:0] r;
    r = `FSPC_UNUSED_RD;
    if (z == `FSPC_Z_LOCK)
      r = {6'h3F, ~lock_prog};
    else if (z == `FSPC_Z_FUSE_LO)
      r = ~low_fuse_prog;
    else if (z == `FSPC_Z_FUSE_HI)
      r = ~high_fuse_prog;
    return r;
  endfunction

  logic       op_busy;
  logic       ee;
  logic       spm_ok;
  logic       start_ers;
  logic       start_wr;
  logic [4:0] wcmd;
  logic       cmd_ok;
  logic [7:0] ctrl_rd;
  logic       setup;
  logic       acc;
  logic       hit;

  ////////////////////////////////////////////////////////////////////////////
  // Shared decode
  // APB timing: pready rises in the cycle after setup and stands for that
  // one access cycle only, so a master sees no wait states. Writes take
  // effect on the edge where psel, penable and pready are all high.
  always_comb begin
    op_busy   = (o_reg.st != FSPC_OP_IDLE);
    ee        = eeprom_write_busy_flag;
    spm_ok    = core_spm && c_reg.cmd[`FSPC_BIT_STORE_ENABLE_BIT] && !op_busy
                && (c_reg.win < `FSPC_SPM_WIN);
    start_ers = spm_ok && c_reg.cmd[`FSPC_BIT_PAGE_ERASE_BIT] && !ee;
    start_wr  = spm_ok && c_reg.cmd[`FSPC_BIT_PAGE_WRITE_BIT] && !ee;
    wcmd      = pwdata[4:0];
    cmd_ok    = (wcmd == `FSPC_CMD_CLR) || (wcmd == `FSPC_CMD_RFL)
                || (wcmd == `FSPC_CMD_WR) || (wcmd == `FSPC_CMD_ERS)
                || (wcmd == `FSPC_CMD_LOAD);
    ctrl_rd   = {3'h0, c_reg.cmd};
    setup     = psel && !penable;
    acc       = psel && penable && c_reg.pready;
    hit       = (paddr == `FSPC_CTRL_ADDR);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register, arm windows, page buffer and byte-load path
  always_comb begin
    c_next             = c_reg;
    c_next.lpm_special = 1'b0;
    c_next.lpm_normal  = 1'b0;
    c_next.ee_q        = ee;
    c_next.buf_rd      = c_reg.buf_w[buf_rd_idx];

    // APB: answer in the cycle after setup, one wait-free access phase
    if (setup) begin
      c_next.pready  = 1'b1;
      c_next.pslverr = !hit;
      c_next.prdata  = hit ? {24'h0, ctrl_rd} : 32'h0;
    end else if (acc) begin
      c_next.pready  = 1'b0;
      c_next.pslverr = 1'b0;
    end

    // Arm window counts only while idle; a running op holds the bits.
    // The fuse/lock read closes one cycle before the store window. An
    // unused read command therefore drops after three cycles, while a
    // store command gets four.
    if (c_reg.cmd[`FSPC_BIT_STORE_ENABLE_BIT] && !op_busy) begin
      c_next.win = c_reg.win + 3'h1;
      if (c_reg.cmd[`FSPC_BIT_FUSE_LOCK_READ_BIT] && c_reg.win == `FSPC_LPM_WIN - 3'h1)
        c_next.cmd = 5'h0;
      if (c_reg.win == `FSPC_SPM_WIN - 3'h1)
        c_next.cmd = 5'h0;
    end

    // Store instruction in an armed window. Erase and write hand over to
    // the op machine and keep their bits until it finishes. A busy EEPROM
    // drops them with no op, and a window expiring on the start edge drops
    // them while the op runs. A plain store
    // or a buffer clear is done here and disarms at once. A slot that is
    // already loaded ignores a second store until the buffer is cleared.
    if (spm_ok) begin
      if (c_reg.cmd[`FSPC_BIT_PAGE_ERASE_BIT] || c_reg.cmd[`FSPC_BIT_PAGE_WRITE_BIT]) begin
        if (ee)
          c_next.cmd = 5'h0;
      end else begin
        c_next.cmd = 5'h0;
        if (c_reg.cmd[`FSPC_BIT_BUFFER_CLEAR_BIT]) begin
          c_next.used = '0;
        end else if (!c_reg.cmd[`FSPC_BIT_FUSE_LOCK_READ_BIT] && !ee
                     && !c_reg.used[slot_of(core_z)]) begin
          c_next.buf_w[slot_of(core_z)] = core_data;
          c_next.used[slot_of(core_z)]  = 1'b1;
        end
      end
    end

    // Byte-load: fuse/lock space while armed, else ordinary flash read.
    // The answer pulse comes one cycle after the load. lpm_data holds its
    // value until the next special read, so the core can take it late.
    if (core_lpm) begin
      c_next.lpm_byte_hi = core_z[0];
      if (c_reg.cmd[`FSPC_BIT_FUSE_LOCK_READ_BIT] && c_reg.cmd[`FSPC_BIT_STORE_ENABLE_BIT]
          && c_reg.win < `FSPC_LPM_WIN && !ee) begin
        c_next.lpm_data    = fuse_read(core_z);
        c_next.lpm_special = 1'b1;
        c_next.cmd         = 5'h0;
      end else begin
        c_next.lpm_normal = 1'b1;
      end
    end

    // Completion of the timed op releases the held bits
    if (o_reg.done)
      c_next.cmd = 5'h0;
    if (o_reg.done_wr)
      c_next.used = '0;

    // EEPROM write starting mid-load throws the buffer away. Only the
    // rising edge counts, so a long EEPROM write clears the buffer once and
    // does not keep erasing words loaded after it ends.
    if (ee && !c_reg.ee_q)
      c_next.used = '0;

    // Register write: valid pattern only, never while busy. It comes last,
    // so a fresh command overrides any clear from an expiring window in the
    // same cycle.
    if (acc && pwrite && hit && cmd_ok && !ee && !op_busy) begin
      c_next.cmd = wcmd;
      c_next.win = 3'h0;
      if (wcmd == `FSPC_CMD_CLR)
        c_next.used = '0;
    end

    // Cleared words read as zero to the flash macro
    if (!c_reg.used[buf_rd_idx])
      c_next.buf_rd = 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timed page erase / page write; a system reset does not cut it short,
  // since a half-programmed page is worse than a late core restart.
  // The timer counts whole clock cycles from the edge that starts the op.
  // OP_CYCLES defaults to the shortest allowed operation, rounded up, so
  // the op never ends early and stays well below the upper limit. A
  // different clock needs OP_CYCLES rescaled, since the count is not tied
  // to an oscillator of its own. Halt and busy rise on the same edge as
  // the go pulse and fall on the edge that returns the state to idle.
  always_comb begin
    o_next          = o_reg;
    o_next.erase_go = 1'b0;
    o_next.write_go = 1'b0;
    o_next.done     = 1'b0;
    o_next.done_wr  = 1'b0;
    case (o_reg.st)
      FSPC_OP_IDLE: begin
        if (start_ers || start_wr) begin
          o_next.st       = start_ers ? FSPC_OP_ERASE : FSPC_OP_WRITE;
          o_next.timer    = '0;
          o_next.page     = (PB+1)'(core_z[15:WB+1]);
          o_next.erase_go = start_ers;
          o_next.write_go = start_wr;
          o_next.halt     = 1'b1;
          o_next.busy     = 1'b1;
        end
      end
      FSPC_OP_ERASE, FSPC_OP_WRITE: begin
        o_next.timer = o_reg.timer + TW'(1);
        if (o_reg.timer == OP_LAST) begin
          o_next.st      = FSPC_OP_IDLE;
          o_next.halt    = 1'b0;
          o_next.busy    = 1'b0;
          o_next.done    = 1'b1;
          o_next.done_wr = (o_reg.st == FSPC_OP_WRITE);
        end
      end
      default: begin
        o_next.st   = FSPC_OP_IDLE;
        o_next.halt = 1'b0;
        o_next.busy = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State registers
  // Each process registers a whole struct at once, so every field of a
  // state group moves on the same edge. The two groups differ only in the
  // reset that clears them.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      c_reg <= '0;
    end else begin
      c_reg <= c_next;
    end
  end

  // Power-on only, so a system reset lets the op finish
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      o_reg <= '0;
    end else begin
      o_reg <= o_next;
    end
  end

  // Outputs straight from flops. None passes through logic, so every
  // output settles right after the edge, and a consumer on the same clock
  // sees no combinational path through this block.
  assign prdata         = c_reg.prdata;
  assign pready         = c_reg.pready;
  assign pslverr        = c_reg.pslverr;
  assign lpm_data       = c_reg.lpm_data;
  assign lpm_special    = c_reg.lpm_special;
  assign lpm_normal     = c_reg.lpm_normal;
  assign lpm_byte_hi    = c_reg.lpm_byte_hi;
  assign buf_rd_data    = c_reg.buf_rd;
  assign core_halt      = o_reg.halt;
  assign flash_page     = o_reg.page;
  assign flash_erase_go = o_reg.erase_go;
  assign flash_write_go = o_reg.write_go;
  assign flash_busy     = o_reg.busy;

endmodule

// ===== fspc_top_tb_top.sv
// Self-checking bench for the flash self-programming controller.
// Assumes fspc_cfg.svh, the core model and the checker in the same folder.
`timescale 1ns/10ps
`include "fspc_cfg.svh"
module fspc_top_tb_top;
  logic        clk, resetn, por_n, psel, penable, pwrite, pready, pslverr, e, sp, nm;
  logic        core_spm, core_lpm, lpm_special, lpm_normal, lpm_byte_hi, core_halt;
  logic        flash_erase_go, flash_write_go, flash_busy, eeprom_write_busy_flag;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] core_z, core_data, buf_rd_data, dat, z;
  logic [10:0] flash_page;
  logic [9:0]  pg;
  logic [7:0]  lpm_data, low_fuse_prog, high_fuse_prog, d, v;
  logic [4:0]  buf_rd_idx, s;
  logic [1:0]  lock_prog;
  integer      seed;
  int          num_errors, checked;
  logic [7:0]  pat [5] = '{8'h11, 8'h09, 8'h05, 8'h03, 8'h01};
  logic [15:0] zl [4] = '{16'h0000, 16'h0001, 16'h0003, 16'h0002};
  fspc_top #(.OP_CYCLES(20)) fspc_top_i (.*);
  fspc_core_model fspc_core_model_i (.*);
  ////////////////////////////////////////////////////////////
  // 20 MHz clock
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  task automatic end_sim;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] x, g);
    checked++;
    if (g !== x) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", n, x, g);
    end
  endtask
  // APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, wd};
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) begin
      num_errors++;
      end_sim();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] x);
    apb(1'h1, `FSPC_CTRL_ADDR, {24'h0, x});
  endtask
  task automatic reg_chk(input logic [31:0] x);
    apb(1'h0, `FSPC_CTRL_ADDR, 32'h0);
    chk("control", x, r);
  endtask
  // Buffer word appears one cycle after its index
  task automatic buf_chk(input logic [4:0] i, input logic [15:0] x);
    @(posedge clk);
    buf_rd_idx <= i;
    repeat (2) @(posedge clk);
    chk("buffer", 32'(x), 32'(buf_rd_data));
  endtask
  task automatic wait_op;
    int n;
    n = 0;
    while (core_halt !== 1'h0 && n < 60) begin
      @(posedge clk);
      n++;
    end
    if (n >= 60) begin
      num_errors++;
      end_sim();
    end
  endtask
  function automatic logic [31:0] cmd_exp(input logic [7:0] x);
    case (x[4:0])
      5'h11, 5'h09, 5'h05, 5'h03, 5'h01: cmd_exp = {27'h0, x[4:0]};
      default: cmd_exp = 32'h0;
    endcase
  endfunction
  // Fuses and locks read back inverted
  function automatic logic [7:0] fuse_exp(input logic [15:0] x);
    case (x)
      16'h0000: fuse_exp = ~low_fuse_prog;
      16'h0001: fuse_exp = {6'h3F, ~lock_prog};
      16'h0003: fuse_exp = ~high_fuse_prog;
      default: fuse_exp = 8'hFF;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    seed = 72;
    {resetn, por_n, psel, penable, pwrite, paddr, pwdata, eeprom_write_busy_flag, buf_rd_idx} = '0;
    {low_fuse_prog, high_fuse_prog, lock_prog} = 18'($random(seed));
    repeat (8) @(posedge clk);
    {resetn, por_n} <= 2'h3;
    reg_chk(32'h0);
    apb(1'h0, 12'h0D8, 32'h0);
    chk("slverr", 32'h1, 32'(e));
    for (int i = 0; i < 17; i++) begin
      v = (i < 5) ? pat[i] : 8'($random(seed));
      wr(v);
      reg_chk(cmd_exp(v));
      repeat (6) @(posedge clk);
      reg_chk(32'h0);
    end
    for (int k = 0; k < 4; k++) begin
      wr(8'h09);
      fspc_core_model_i.load_program_memory_instr(zl[k], sp, nm, d);
      chk("special", 32'h1, 32'(sp));
      chk("fuse", 32'(fuse_exp(zl[k])), 32'(d));
      reg_chk(32'h0);
    end
    wr(8'h09);
    repeat (4) @(posedge clk);
    z = 16'($random(seed));
    fspc_core_model_i.load_program_memory_instr(z, sp, nm, d);
    chk("normal", 32'h1, 32'(nm));
    chk("byte_hi", 32'(z[0]), 32'(lpm_byte_hi));
    eeprom_write_busy_flag <= 1'h1;
    wr(8'h09);
    fspc_core_model_i.load_program_memory_instr(16'h0000, sp, nm, d);
    chk("normal", 32'h1, 32'(nm));
    eeprom_write_busy_flag <= 1'h0;
    {s, dat, pg} = 31'($random(seed));
    wr(8'h01);
    fspc_core_model_i.store_program_memory_instr({10'h0, s, 1'h1}, dat);
    buf_chk(s, dat);
    wr(8'h01);
    fspc_core_model_i.store_program_memory_instr({10'h0, s, 1'h0}, ~dat);
    buf_chk(s, dat);
    wr(8'h11);
    buf_chk(s, 16'h0);
    wr(8'h01);
    repeat (6) @(posedge clk);
    fspc_core_model_i.store_program_memory_instr({10'h0, s, 1'h0}, dat);
    buf_chk(s, 16'h0);
    wr(8'h01);
    fspc_core_model_i.store_program_memory_instr({10'h0, s, 1'h0}, dat);
    eeprom_write_busy_flag <= 1'h1;
    @(posedge clk);
    eeprom_write_busy_flag <= 1'h0;
    buf_chk(s, 16'h0);
    wr(8'h03);
    fspc_core_model_i.store_program_memory_instr({pg, 6'h0}, dat);
    @(posedge clk);
    chk("erase_go", 32'h1, 32'(flash_erase_go));
    chk("page", 32'(pg), 32'(flash_page));
    chk("busy", 32'h1, 32'(flash_busy));
    reg_chk(32'h3);
    resetn <= 1'h0;
    @(posedge clk);
    resetn <= 1'h1;
    @(posedge clk);
    chk("halt", 32'h1, 32'(core_halt));
    wait_op();
    reg_chk(32'h0);
    wr(8'h01);
    fspc_core_model_i.store_program_memory_instr({10'h0, s, 1'h0}, dat);
    wr(8'h05);
    fspc_core_model_i.store_program_memory_instr({pg, 6'h0}, 16'h0);
    @(posedge clk);
    chk("write_go", 32'h1, 32'(flash_write_go));
    wait_op();
    reg_chk(32'h0);
    buf_chk(s, 16'h0);
    end_sim();
  end
endmodule
